// *** twmc_top.sv ***
// Timer waveform mode control with counter, compare and AXI4-Lite registers.
`timescale 1ns/1ps
// Function
// - Nonzero channel A action takes the A pin; direction bit enables driver.
// - Nonzero channel B action takes the B pin; direction bit enables driver.
// - Non-PWM channel A: off, toggle, clear or set on match.
// - Fast PWM A: 01 toggles only with mode msb; 10/11 match and TOP.
// - Phase PWM A: 01 as fast; 10/11 act by count direction.
// - PWM A with match equal TOP and action msb: ignore match, act at TOP.
// - Non-PWM channel B: off, toggle, clear or set on match.
// - Fast PWM B: 01 reserved without toggle; 10/11 match and TOP.
// - Phase PWM B: 01 reserved; 10/11 act by count direction.
// - PWM B with match equal TOP and action msb: ignore match, act at TOP.
// - Control A bits three and two always read zero.
// - Mode number is msb from control B plus two low bits from A.
// - Modes 0 and 2 update compares at once, wrap flag at MAX.
// - PWM updates compares at TOP; wrap flag at BOTTOM, MAX or TOP.
// - Only the four mode kinds exist; codes 4 and 6 are reserved.
// - MAX is 0xFF and BOTTOM is 0x00.
// - Clock pick selects stop, divide 1 to 1024, or external edges.
// - Force strobe in non-PWM applies the action at once, reads zero.
module twmc_top #(
  parameter int ADDR_W = 8,
  parameter int PRE_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_pin,
  input wire logic dir_a,
  input wire logic dir_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic pin_a_take,
  output logic pin_b_take,
  output logic pin_a_oe,
  output logic pin_b_oe
);

  if (ADDR_W < 8 || PRE_W < 10) begin : g_bad_param
    $error("twmc_top needs ADDR_W of at least 8 and PRE_W of at least 10");
  end

  // Is the register index one that this block answers?
  function automatic logic idx_mapped(input logic [5:0] idx);
    return idx == twmc_pkg::IDX_CTL_A || idx == twmc_pkg::IDX_CTL_B ||
           idx == twmc_pkg::IDX_COUNT || idx == twmc_pkg::IDX_MATCH_A ||
           idx == twmc_pkg::IDX_MATCH_B || idx == twmc_pkg::IDX_STATUS;
  endfunction : idx_mapped

  // Next output level of one compare channel.
  function automatic logic act_next(input logic [1:0] act,
                                    input logic [2:0] mode,
                                    input logic toggle_ok,
                                    input logic up, input logic hit,
                                    input logic at_top, input logic cur);
    logic res;
    res = cur;
    if (hit) begin
      if (act == twmc_pkg::ACT_TOGGLE) begin
        if (!mode[0] || toggle_ok) begin
          res = ~cur;
        end
      end else if (act[1]) begin
        if (mode[1:0] == 2'h1) begin
          res = up ? act[0] : ~act[0];
        end else begin
          res = act[0];
        end
      end
    end
    if (at_top && act[1]) begin
      res = ~act[0];
    end
    return res;
  endfunction : act_next

  logic awready_q, aw_have_q, wready_q, w_have_q, bvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] act_a_q, act_b_q, wm_lo_q;
  logic wm_msb_q;
  logic [2:0] clock_pick_q;
  logic [7:0] match_a_buf_q, match_b_buf_q, match_a_q, match_b_q;
  logic [7:0] count_q;
  logic up_q, block_q, wrap_flag_q;
  logic [PRE_W-1:0] pre_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic wave_a_q, wave_b_q, take_a_q, take_b_q, oe_a_q, oe_b_q;
  logic wr_go, wr_en;
  logic [5:0] wr_idx, rd_idx;
  logic [2:0] wave_mode;
  logic pwm, fast, phase;
  logic [7:0] top;
  logic tick, at_top, cnt_wr, force_a, force_b, hit_a, hit_b;
  logic top_a, top_b;
  logic [31:0] rd_word;

  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = aw_addr_q[7:2];
  assign wr_en = wr_go && w_strb_q;
  assign rd_idx = s_axi_araddr[7:2];

  assign wave_mode = {wm_msb_q, wm_lo_q};
  // Reserved codes 4 and 6 fall back to plain up counting to MAX.
  assign pwm = wave_mode[0];
  assign fast = wave_mode[1:0] == 2'h3;
  assign phase = wave_mode[1:0] == 2'h1;
  assign top = (wave_mode == twmc_pkg::WM_CLEAR ||
                wave_mode == twmc_pkg::WM_PHASE_A ||
                wave_mode == twmc_pkg::WM_FAST_A) ?
               match_a_q : twmc_pkg::CNT_MAX;
  assign at_top = tick && count_q == top;
  assign cnt_wr = wr_en && wr_idx == twmc_pkg::IDX_COUNT;

  // Count source selection from the prescaler or the external pin.
  always_comb begin
    case (clock_pick_q)
      twmc_pkg::CLK_STOP: tick = 1'b0;
      twmc_pkg::CLK_DIV1: tick = 1'b1;
      twmc_pkg::CLK_DIV8: tick = &pre_q[$clog2(twmc_pkg::DIV_8)-1:0];
      twmc_pkg::CLK_DIV64: tick = &pre_q[$clog2(twmc_pkg::DIV_64)-1:0];
      twmc_pkg::CLK_DIV256: tick = &pre_q[$clog2(twmc_pkg::DIV_256)-1:0];
      twmc_pkg::CLK_DIV1024: tick = &pre_q[$clog2(twmc_pkg::DIV_1024)-1:0];
      twmc_pkg::CLK_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
      default: tick = !ext_s3_q && ext_s2_q;
    endcase
  end

  assign force_a = wr_en && wr_idx == twmc_pkg::IDX_CTL_B && !pwm &&
                   w_data_q[twmc_pkg::CTB_FORCE_A];
  assign force_b = wr_en && wr_idx == twmc_pkg::IDX_CTL_B && !pwm &&
                   w_data_q[twmc_pkg::CTB_FORCE_B];
  // A match equal to TOP is dropped in PWM when the action msb is set.
  assign hit_a = (tick && !block_q && count_q == match_a_q &&
                  !(pwm && match_a_q == top && act_a_q[1])) ||
                 force_a;
  assign hit_b = (tick && !block_q && count_q == match_b_q &&
                  !(pwm && match_b_q == top && act_b_q[1])) ||
                 force_b;
  // Fast PWM acts at every TOP; phase correct only when match sits at TOP.
  assign top_a = (fast && at_top) ||
                 (phase && at_top && match_a_q == top);
  assign top_b = (fast && at_top) ||
                 (phase && at_top && match_b_q == top);

  always_comb begin
    rd_word = '0;
    if (rd_idx == twmc_pkg::IDX_CTL_A) begin
      rd_word[7:0] = {act_a_q, act_b_q, 2'h0, wm_lo_q};
    end else if (rd_idx == twmc_pkg::IDX_CTL_B) begin
      rd_word[7:0] = {4'h0, wm_msb_q, clock_pick_q};
    end else if (rd_idx == twmc_pkg::IDX_COUNT) begin
      rd_word[7:0] = count_q;
    end else if (rd_idx == twmc_pkg::IDX_MATCH_A) begin
      rd_word[7:0] = match_a_buf_q;
    end else if (rd_idx == twmc_pkg::IDX_MATCH_B) begin
      rd_word[7:0] = match_b_buf_q;
    end else if (rd_idx == twmc_pkg::IDX_STATUS) begin
      rd_word[twmc_pkg::ST_WRAP] = wrap_flag_q;
    end
  end

  // Write address and data channels, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= twmc_pkg::DATA_RESET;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= twmc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= idx_mapped(wr_idx) ? twmc_pkg::RESP_OKAY :
                   twmc_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= twmc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= idx_mapped(rd_idx) ? twmc_pkg::RESP_OKAY :
                   twmc_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // Control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_a_q <= twmc_pkg::CTL_A_RESET[twmc_pkg::CTA_ACT_A_LSB +: 2];
      act_b_q <= twmc_pkg::CTL_A_RESET[twmc_pkg::CTA_ACT_B_LSB +: 2];
      wm_lo_q <= twmc_pkg::CTL_A_RESET[twmc_pkg::CTA_WM_LSB +: 2];
      wm_msb_q <= twmc_pkg::CTL_B_RESET[twmc_pkg::CTB_WM_MSB];
      clock_pick_q <= twmc_pkg::CTL_B_RESET[twmc_pkg::CTB_CLK_LSB +: 3];
    end else if (ce && wr_en) begin
      if (wr_idx == twmc_pkg::IDX_CTL_A) begin
        act_a_q <= w_data_q[twmc_pkg::CTA_ACT_A_LSB +: 2];
        act_b_q <= w_data_q[twmc_pkg::CTA_ACT_B_LSB +: 2];
        wm_lo_q <= w_data_q[twmc_pkg::CTA_WM_LSB +: 2];
      end else if (wr_idx == twmc_pkg::IDX_CTL_B) begin
        wm_msb_q <= w_data_q[twmc_pkg::CTB_WM_MSB];
        clock_pick_q <= w_data_q[twmc_pkg::CTB_CLK_LSB +: 3];
      end
    end
  end

  // Compare buffers; the active value follows at once or at TOP.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_a_buf_q <= twmc_pkg::DATA_RESET;
      match_b_buf_q <= twmc_pkg::DATA_RESET;
      match_a_q <= twmc_pkg::DATA_RESET;
      match_b_q <= twmc_pkg::DATA_RESET;
    end else if (ce) begin
      if (wr_en && wr_idx == twmc_pkg::IDX_MATCH_A) begin
        match_a_buf_q <= w_data_q;
      end
      if (wr_en && wr_idx == twmc_pkg::IDX_MATCH_B) begin
        match_b_buf_q <= w_data_q;
      end
      if (!pwm || at_top) begin
        match_a_q <= match_a_buf_q;
        match_b_q <= match_b_buf_q;
      end
    end
  end

  // Prescaler and external clock synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (ce) begin
      pre_q <= pre_q + PRE_W'(1);
      ext_s1_q <= ext_clk_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Counter; a software write blocks the match on the next count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= twmc_pkg::CNT_BOTTOM;
      up_q <= 1'b1;
      block_q <= 1'b0;
    end else if (ce) begin
      if (cnt_wr) begin
        count_q <= w_data_q;
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
        if (phase) begin
          if (up_q && count_q == top) begin
            up_q <= 1'b0;
            count_q <= count_q - 8'h01;
          end else if (!up_q && count_q == twmc_pkg::CNT_BOTTOM) begin
            up_q <= 1'b1;
            count_q <= count_q + 8'h01;
          end else begin
            count_q <= up_q ? count_q + 8'h01 : count_q - 8'h01;
          end
        end else begin
          up_q <= 1'b1;
          count_q <= (count_q == top) ? twmc_pkg::CNT_BOTTOM :
                     count_q + 8'h01;
        end
      end
    end
  end

  // Wrap flag; a new event wins over a clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag_q <= 1'b0;
    end else if (ce) begin
      if ((phase && tick && !up_q &&
           count_q == twmc_pkg::CNT_BOTTOM) ||
          (wave_mode == twmc_pkg::WM_FAST_A && at_top) ||
          (!phase && wave_mode != twmc_pkg::WM_FAST_A && tick &&
           count_q == twmc_pkg::CNT_MAX)) begin
        wrap_flag_q <= 1'b1;
      end else if (wr_en && wr_idx == twmc_pkg::IDX_STATUS &&
                   w_data_q[twmc_pkg::ST_WRAP]) begin
        wrap_flag_q <= 1'b0;
      end
    end
  end

  // Waveform levels and pin takeover.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      take_a_q <= 1'b0;
      take_b_q <= 1'b0;
      oe_a_q <= 1'b0;
      oe_b_q <= 1'b0;
    end else if (ce) begin
      wave_a_q <= act_next(act_a_q, wave_mode, wm_msb_q, up_q, hit_a,
                           top_a, wave_a_q);
      wave_b_q <= act_next(act_b_q, wave_mode, 1'b0, up_q, hit_b,
                           top_b, wave_b_q);
      take_a_q <= |act_a_q;
      take_b_q <= |act_b_q;
      oe_a_q <= (|act_a_q) && dir_a;
      oe_b_q <= (|act_b_q) && dir_b;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  assign pin_a_take = take_a_q;
  assign pin_b_take = take_b_q;
  assign pin_a_oe = oe_a_q;
  assign pin_b_oe = oe_b_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_read_ctl_a;
    s_axi_arvalid && arready_q && rd_idx == twmc_pkg::IDX_CTL_A;
  endsequence
  sequence s_read_ctl_b;
    s_axi_arvalid && arready_q && rd_idx == twmc_pkg::IDX_CTL_B;
  endsequence
  sequence s_take_a_write;
    wr_en && wr_idx == twmc_pkg::IDX_CTL_A && w_data_q[7:6] != 2'h0;
  endsequence
  sequence s_normal_max;
    wave_mode == twmc_pkg::WM_NORMAL && tick &&
    count_q == twmc_pkg::CNT_MAX;
  endsequence

  a_ctl_a_reserved: assert property (
    s_read_ctl_a |=> s_axi_rvalid && s_axi_rdata[3:2] == 2'h0)
    else $error("control A reserved bits read nonzero");
  a_force_reads_zero: assert property (
    s_read_ctl_b |=> s_axi_rvalid && s_axi_rdata[7:4] == 4'h0)
    else $error("force strobes read nonzero");
  a_pin_a_takeover: assert property (
    s_take_a_write |=> ##1 pin_a_take)
    else $error("channel A pin not taken after nonzero action");
  a_oe_needs_dir: assert property (
    pin_b_oe |-> pin_b_take && $past(dir_b))
    else $error("channel B driver on without direction bit");
  a_wrap_at_max: assert property (
    s_normal_max |=> wrap_flag_q)
    else $error("wrap flag not set at MAX in normal mode");
  a_clear_on_match: assert property (
    !pwm && act_a_q == twmc_pkg::ACT_CLEAR && hit_a |=> !wave_out_a)
    else $error("channel A not cleared on match");
  a_fast_top_set: assert property (
    fast && act_b_q == twmc_pkg::ACT_CLEAR && at_top |=> wave_out_b)
    else $error("channel B not set at TOP in fast PWM");
  a_b_no_toggle: assert property (
    pwm && act_b_q == twmc_pkg::ACT_TOGGLE |=> $stable(wave_out_b))
    else $error("channel B changed with reserved PWM action");
  a_clock_stopped: assert property (
    clock_pick_q == twmc_pkg::CLK_STOP && !cnt_wr [*2] |=>
    $stable(count_q))
    else $error("counter moved while stopped");
  a_phase_turn: assert property (
    phase && tick && up_q && count_q == top && !cnt_wr |=>
    !up_q && count_q == $past(top) - 8'h01)
    else $error("phase correct count did not turn at TOP");
  a_write_answer: assert property (
    wr_go |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready))
    else $error("write response missing");

endmodule : twmc_top

// *** twmc_pkg.sv ***
// Constants shared by the timer waveform mode control block.
package twmc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CTL_A = 6'h2f;
  localparam logic [5:0] IDX_CTL_B = 6'h33;
  localparam logic [5:0] IDX_COUNT = 6'h32;
  localparam logic [5:0] IDX_MATCH_A = 6'h36;
  localparam logic [5:0] IDX_MATCH_B = 6'h37;
  localparam logic [5:0] IDX_STATUS = 6'h38;
  // Field positions of timer_control_a.
  localparam int CTA_ACT_A_LSB = 6;
  localparam int CTA_ACT_B_LSB = 4;
  localparam int CTA_WM_LSB = 0;
  // Field positions of timer_control_b.
  localparam int CTB_FORCE_A = 7;
  localparam int CTB_FORCE_B = 6;
  localparam int CTB_WM_MSB = 3;
  localparam int CTB_CLK_LSB = 0;
  // Field position of the status register.
  localparam int ST_WRAP = 1;
  // Reset values.
  localparam logic [7:0] CTL_A_RESET = 8'h00;
  localparam logic [7:0] CTL_B_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Count limits.
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // Waveform mode numbers.
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_FF = 3'h1;
  localparam logic [2:0] WM_CLEAR = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PHASE_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;
  // Output action codes.
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Clock pick codes and prescale divisors.
  localparam logic [2:0] CLK_STOP = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_DIV1024 = 3'h5;
  localparam logic [2:0] CLK_EXT_FALL = 3'h6;
  localparam logic [2:0] CLK_EXT_RISE = 3'h7;
  localparam int DIV_8 = 8;
  localparam int DIV_64 = 64;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : twmc_pkg

// *** twmc_port_model.sv ***
// Port-side model: pin direction bits, external count pin and pad levels.
`timescale 1ns/1ps
module twmc_port_model (
  input wire logic aclk,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic wave_a,
  input wire logic wave_b,
  input wire logic oe_a,
  input wire logic oe_b,
  output logic dir_a,
  output logic dir_b,
  output logic ext_clk,
  output logic pad_a,
  output logic pad_b
);
  logic dir_a_q = 1'b0;
  logic dir_b_q = 1'b0;
  logic [1:0] div_q = 2'h0;
  always_ff @(posedge aclk) begin
    dir_a_q <= want_a;
    dir_b_q <= want_b;
    div_q <= div_q + 2'h1;
  end
  assign dir_a = dir_a_q;
  assign dir_b = dir_b_q;
  assign ext_clk = div_q[1];
  // A pad whose driver is off floats to its pull-up.
  assign pad_a = oe_a ? wave_a : 1'b1;
  assign pad_b = oe_b ? wave_b : 1'b1;
endmodule : twmc_port_model

// *** timer_waveform_mode_control_bench.sv ***
// Self-checking bench for the timer waveform mode control block.
`timescale 1ns/1ps
module timer_waveform_mode_control_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] c1;
  logic awready, wready, bvalid, arready, rvalid, ext_clk, dir_a, dir_b;
  logic wave_a, wave_b, take_a, take_b, oe_a, oe_b, pad_a, pad_b;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  int miscompares = 0;
  int check_count = 0;
  int ha, hb;
  logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] pa [5] = '{8'hb3, 8'h93, 8'hb1, 8'h63, 8'hf3};
  logic [7:0] pb [5] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h01};
  logic [7:0] ma [5] = '{8'h80, 8'hff, 8'h40, 8'h7f, 8'hff};
  logic [7:0] mb [5] = '{8'h40, 8'h40, 8'h40, 8'h20, 8'hff};
  int ea [5] = '{129, 256, 128, 128, 0};
  int eb [5] = '{191, -1, 382, 66, 0};
  int pw [5] = '{256, 256, 510, 256, 256};

  always #12.5 aclk = ~aclk;

  twmc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_clk_pin(ext_clk), .dir_a(dir_a),
    .dir_b(dir_b), .wave_out_a(wave_a), .wave_out_b(wave_b),
    .pin_a_take(take_a), .pin_b_take(take_b), .pin_a_oe(oe_a),
    .pin_b_oe(oe_b));

  twmc_port_model u_port (.aclk(aclk), .want_a(want_a), .want_b(want_b),
    .wave_a(wave_a), .wave_b(wave_b), .oe_a(oe_a), .oe_b(oe_b),
    .dir_a(dir_a), .dir_b(dir_b), .ext_clk(ext_clk), .pad_a(pad_a),
    .pad_b(pad_b));

  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic tmo(input int n);
    if (n > 100) begin
      miscompares++;
      $display("mismatch at %0t: bus answer never came", $time);
      wrap_up();
    end
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got < exp - 4 || got > exp + 4) begin
      miscompares++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      tmo(n);
    end while (aw || w || !bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [5:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    logic ar;
    n = 0;
    ar = 1'b1;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      tmo(n);
    end while (ar || !rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(twmc_pkg::IDX_CTL_A, rd, rsp);
    chk(rd, 32'h0);
    rdr(twmc_pkg::IDX_CTL_B, rd, rsp);
    chk(rd, 32'h0);
    wr(twmc_pkg::IDX_CTL_A, 8'hff, rsp);
    chk({30'h0, rsp}, {30'h0, twmc_pkg::RESP_OKAY});
    rdr(twmc_pkg::IDX_CTL_A, rd, rsp);
    chk(rd, 32'hf3);
    wr(twmc_pkg::IDX_CTL_B, 8'hfd, rsp);
    rdr(twmc_pkg::IDX_CTL_B, rd, rsp);
    chk(rd, 32'h0d);
    wr(6'h00, 8'h5a, rsp);
    chk({30'h0, rsp}, {30'h0, twmc_pkg::RESP_SLVERR});
    rdr(6'h00, rd, rsp);
    chk({rd[29:0], rsp}, {30'h0, twmc_pkg::RESP_SLVERR});
    // Forced matches with the count stopped, normal and clear modes.
    want_a <= 1'b1;
    want_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(twmc_pkg::IDX_CTL_A, {acts[i], acts[i], 2'b00, i[1], 1'b0}, rsp);
      wr(twmc_pkg::IDX_CTL_B, 8'hc0, rsp);
      repeat (3) @(posedge aclk);
      chk({31'h0, wave_a}, {31'h0, exps[i]});
      chk({31'h0, wave_b}, {31'h0, exps[i]});
    end
    chk({29'h0, take_a, oe_a, pad_a}, 32'h6);
    chk({30'h0, take_b, oe_b}, 32'h3);
    want_a <= 1'b0;
    want_b <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({30'h0, oe_a, pad_a}, 32'h1);
    chk({30'h0, oe_b, pad_b}, 32'h1);
    wr(twmc_pkg::IDX_CTL_A, 8'h00, rsp);
    repeat (3) @(posedge aclk);
    chk({30'h0, take_a, take_b}, 32'h0);
    want_a <= 1'b1;
    want_b <= 1'b1;
    wr(twmc_pkg::IDX_CTL_A, 8'hf3, rsp);
    wr(twmc_pkg::IDX_CTL_B, 8'hc0, rsp);
    repeat (3) @(posedge aclk);
    chk({31'h0, wave_a}, 32'h0);
    // Wrap flag in normal mode, then write one to clear it.
    wr(twmc_pkg::IDX_CTL_A, 8'h00, rsp);
    wr(twmc_pkg::IDX_STATUS, 8'h02, rsp);
    wr(twmc_pkg::IDX_COUNT, 8'hf0, rsp);
    wr(twmc_pkg::IDX_CTL_B, 8'h01, rsp);
    repeat (40) @(posedge aclk);
    rdr(twmc_pkg::IDX_STATUS, rd, rsp);
    chk(rd & 32'h2, 32'h2);
    wr(twmc_pkg::IDX_STATUS, 8'h02, rsp);
    rdr(twmc_pkg::IDX_STATUS, rd, rsp);
    chk(rd & 32'h2, 32'h0);
    // Duty of each waveform over one window of pw counts per setting; mode 7 spans two counter periods.
    for (int i = 0; i < 5; i++) begin
      wr(twmc_pkg::IDX_MATCH_A, ma[i], rsp);
      wr(twmc_pkg::IDX_MATCH_B, mb[i], rsp);
      wr(twmc_pkg::IDX_CTL_A, pa[i], rsp);
      wr(twmc_pkg::IDX_CTL_B, pb[i], rsp);
      repeat (600) @(posedge aclk);
      ha = 0;
      hb = 0;
      for (int k = 0; k < pw[i]; k++) begin
        @(posedge aclk);
        ha += int'(wave_a === 1'b1);
        hb += int'(wave_b === 1'b1);
      end
      chk_n(ha, ea[i]);
      if (eb[i] < 0) begin
        chk_n(hb % pw[i], 0);
      end else begin
        chk_n(hb, eb[i]);
      end
    end
    // Count rates of a divided and of the external source.
    wr(twmc_pkg::IDX_CTL_B, 8'h02, rsp);
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    c1 = rd[7:0];
    repeat (80) @(posedge aclk);
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    chk_n(int'(8'(rd[7:0] - c1)), 10);
    wr(twmc_pkg::IDX_CTL_B, 8'h07, rsp);
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    c1 = rd[7:0];
    repeat (80) @(posedge aclk);
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    chk_n(int'(8'(rd[7:0] - c1)), 21);
    // A low clock enable freezes the counter with the bus idle.
    wr(twmc_pkg::IDX_CTL_B, 8'h01, rsp);
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    c1 = rd[7:0];
    ce <= 1'b0;
    repeat (50) @(posedge aclk);
    ce <= 1'b1;
    rdr(twmc_pkg::IDX_COUNT, rd, rsp);
    chk_n(int'(8'(rd[7:0] - c1)), 3);
    wrap_up();
  end
endmodule : timer_waveform_mode_control_bench
